// ===== logic/irs_pkg.sv
// Shared constants, types and helpers of the image readout sequencer
package irs_pkg;
  localparam int CW = 12;
  localparam int PW = 10;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_NPIX = 8'h04;
  localparam logic [7:0] A_NLINES = 8'h08;
  localparam logic [7:0] A_DELAY = 8'h0c;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [3:0] U_CTRL = 4'h0;
  localparam logic [3:0] U_NPIX = 4'h1;
  localparam logic [3:0] U_NLINES = 4'h2;
  localparam logic [3:0] U_DELAY = 4'h3;
  localparam int CTRL_ONE_OUT = 0;
  localparam int CTRL_ADC_ONE = 1;
  localparam int CTRL_SWITCH = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [CW-1:0] NPIX_RST = 12'h280;
  localparam logic [CW-1:0] NLINES_RST = 12'h1e0;
  localparam logic [7:0] DELAY_RST = 8'h00;
  localparam int UP_LEN = 16;
  localparam int UP_AW = 4;
  localparam int UP_DW = 12;
  localparam int SYS_CLK_MHZ = 10;
  localparam int BLANK_NS = 1000;
  localparam int BLANK_CYC = (BLANK_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] BLANK_LAST = 8'(BLANK_CYC - 1);
  localparam logic [7:0] MARK_LAST = 8'h01;
  localparam int LAT_TWO = 4;
  localparam int LAT_ONE = 5;
  localparam int DLY_TAPS = 13;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_SUSP = 3'b010,
    ST_BLANK = 3'b011,
    ST_READ = 3'b100,
    ST_EOL = 3'b101
  } irs_state_e;

  // Level filter: a change counts once second and third stages agree
  function automatic logic irs_filt_f(input logic [2:0] sh, input logic prev);
    return (sh[1] == sh[2]) ? sh[2] : prev;
  endfunction

  // Delay code to added system clock periods
  function automatic logic [3:0] irs_dly_f(input logic [3:0] c);
    return (c >= 4'h3) ? c - 4'h2 : 4'h0;
  endfunction

  // Delayed tap of a history line
  function automatic logic irs_tap_f(input logic [DLY_TAPS-1:0] h, input logic [3:0] d,
                                     input logic now);
    return (d == 4'h0) ? now : h[d - 4'h1];
  endfunction
endpackage

// ===== logic/irs_par_if.sv
// Internal parameter bus from the serial upload to the sequencer
`timescale 1ns/1ns
interface irs_par_if;
  logic wr;
  logic [irs_pkg::UP_AW-1:0] addr;
  logic [irs_pkg::UP_DW-1:0] data;
  modport src (output wr, output addr, output data);
  modport dst (input wr, input addr, input data);
endinterface

// ===== logic/irs_upload.sv
// Serial parameter upload with register clock latch
`timescale 1ns/1ns
module irs_upload (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic upload_clk_i,
  input wire logic upload_data_i,
  input wire logic reg_clock_i,
  irs_par_if.src par
);
  import irs_pkg::*;

  typedef struct packed {
    logic [2:0] ck_sh;
    logic [2:0] dt_sh;
    logic [2:0] rc_sh;
    logic ck;
    logic dt;
    logic rc;
    logic [UP_LEN-1:0] shift;
    logic wr;
    logic [UP_AW-1:0] addr;
    logic [UP_DW-1:0] data;
  } irs_up_s;

  irs_up_s up_reg;
  irs_up_s up_next;

  always_comb begin
    up_next = up_reg;
    up_next.ck_sh = {up_reg.ck_sh[1:0], upload_clk_i};
    up_next.dt_sh = {up_reg.dt_sh[1:0], upload_data_i};
    up_next.rc_sh = {up_reg.rc_sh[1:0], reg_clock_i};
    up_next.ck = irs_filt_f(up_reg.ck_sh, up_reg.ck);
    up_next.dt = irs_filt_f(up_reg.dt_sh, up_reg.dt);
    up_next.rc = irs_filt_f(up_reg.rc_sh, up_reg.rc);
    up_next.wr = 1'b0;
    if (up_next.ck && !up_reg.ck) begin
      up_next.shift = {up_reg.shift[UP_LEN-2:0], up_reg.dt};
    end
    if (up_next.rc && !up_reg.rc) begin
      up_next.wr = 1'b1;
      up_next.addr = up_reg.shift[UP_LEN-1:UP_DW];
      up_next.data = up_reg.shift[UP_DW-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_reg <= '0;
    end else begin
      up_reg <= up_next;
    end
  end

  assign par.wr = up_reg.wr;
  assign par.addr = up_reg.addr;
  assign par.data = up_reg.data;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_shift_in;
    $rose(up_reg.ck) |-> up_reg.shift == {$past(up_reg.shift[UP_LEN-2:0]), $past(up_reg.dt)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("upload shift wrong");

  property p_latch;
    up_reg.wr |-> {up_reg.addr, up_reg.data} == $past(up_reg.shift) && $rose(up_reg.rc);
  endproperty
  a_latch: assert property (p_latch) else $error("register latch wrong");

  c_write: cover property (up_reg.wr);
endmodule

// ===== logic/irs_core.sv
// Image readout sequencer: frame/line timing, pixel and converter paths, Wishbone registers
// Behaviour
// - Line input held high suspends sequencing
// - Blanking samples signal, reset, then reads
// - Pixel window rises at column readout start
// - Window falls when pixel count reaches setting
// - End-of-line one cycle after window fall
// - End-of-frame after last line fully read
// - Markers may feed back with two-cycle delay
// - Two outputs: data valid four cycles later
// - One output: data valid five cycles later
// - Window and markers have programmable delay
// - Converters sample falling half-rate clock edge
// - Two converters: two-cycle pipeline each
// - Single converter: falling edge, two-cycle pipeline
// - Upload shifts on upload clock rise
// - Upload word 16 bits, address first, MSB first
// - Register clock rise copies word to register
// - Active-high reset clears sequencer state
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
module irs_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic line_adv_i,
  input wire logic frame_start_i,
  input wire logic upload_clk_i,
  input wire logic upload_data_i,
  input wire logic reg_clock_i,
  input wire logic [irs_pkg::PW-1:0] pix_a_i,
  input wire logic [irs_pkg::PW-1:0] pix_b_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic pix_valid_o,
  output logic eol_o,
  output logic eof_o,
  output logic sample_sig_o,
  output logic sample_rst_o,
  output logic [irs_pkg::CW-1:0] col_addr_o,
  output logic [irs_pkg::PW-1:0] analog_output_a_o,
  output logic [irs_pkg::PW-1:0] analog_output_b_o,
  output logic out_valid_o,
  output logic adc_clk_o,
  output logic [irs_pkg::PW-1:0] adc_data_o
);
  import irs_pkg::*;

  typedef struct packed {
    logic [2:0] lc_sh;
    logic [2:0] fs_sh;
    logic lc;
    logic fs;
    irs_state_e st;
    logic [CW-1:0] pix_cnt;
    logic [CW-1:0] line_cnt;
    logic [7:0] bc;
    logic pv_raw;
    logic eol_raw;
    logic eof_raw;
    logic [DLY_TAPS-1:0] pv_h;
    logic [DLY_TAPS-1:0] eol_h;
    logic [DLY_TAPS-1:0] eof_h;
    logic pv_o;
    logic eol_o;
    logic eof_o;
    logic smp_sig;
    logic smp_rst;
    logic [2:0] ctrl;
    logic [CW-1:0] npix;
    logic [CW-1:0] nlines;
    logic [7:0] dly;
    logic ack;
    logic [31:0] rdat;
    logic [3:0][PW-1:0] pa;
    logic [3:0][PW-1:0] pb;
    logic [3:0] pvp;
    logic [PW-1:0] oa;
    logic [PW-1:0] ob;
    logic ov;
    logic adc_clk;
    logic [1:0][PW-1:0] c1;
    logic [1:0][PW-1:0] c2;
    logic [PW-1:0] adc_d;
  } irs_core_s;

  irs_core_s core_reg;
  irs_core_s core_next;
  irs_par_if par ();

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] irs_merge_f(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  irs_upload u_upload (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .upload_clk_i(upload_clk_i),
    .upload_data_i(upload_data_i),
    .reg_clock_i(reg_clock_i),
    .par(par.src)
  );

  always_comb begin
    logic [PW-1:0] ain;
    logic [3:0] dpv;
    logic [3:0] dmk;
    logic one;
    logic [31:0] wv;
    ain = '0;
    dpv = '0;
    dmk = '0;
    one = 1'b0;
    wv = '0;
    core_next = core_reg;
    core_next.lc_sh = {core_reg.lc_sh[1:0], line_adv_i};
    core_next.fs_sh = {core_reg.fs_sh[1:0], frame_start_i};
    core_next.lc = irs_filt_f(core_reg.lc_sh, core_reg.lc);
    core_next.fs = irs_filt_f(core_reg.fs_sh, core_reg.fs);
    core_next.smp_sig = 1'b0;
    core_next.smp_rst = 1'b0;
    case (core_reg.st)
      ST_IDLE, ST_WAIT: begin
        if (core_next.fs && !core_reg.fs) begin
          core_next.line_cnt = '0;
          core_next.st = ST_WAIT;
        end else if (core_reg.st == ST_WAIT && core_next.lc) begin
          core_next.st = ST_SUSP;
        end
      end
      ST_SUSP: begin
        if (!core_next.lc) begin
          core_next.st = ST_BLANK;
          core_next.bc = '0;
          core_next.pix_cnt = '0;
        end
      end
      ST_BLANK: begin
        if (!core_next.lc) begin
          core_next.bc = core_reg.bc + 8'h01;
          core_next.smp_sig = (core_reg.bc == 8'h00);
          core_next.smp_rst = (core_reg.bc == 8'h01);
          if (core_reg.bc == BLANK_LAST) begin
            core_next.st = ST_READ;
          end
        end
      end
      ST_READ: begin
        if (!core_next.lc) begin
          core_next.pix_cnt = core_reg.pix_cnt + 12'h001;
          if (core_next.pix_cnt >= core_reg.npix) begin
            core_next.st = ST_EOL;
            core_next.bc = '0;
            core_next.line_cnt = core_reg.line_cnt + 12'h001;
          end
        end
      end
      ST_EOL: begin
        core_next.bc = core_reg.bc + 8'h01;
        if (core_reg.bc == MARK_LAST) begin
          core_next.st = (core_reg.line_cnt >= core_reg.nlines) ? ST_IDLE : ST_WAIT;
        end
      end
      default: begin
        core_next.st = ST_IDLE;
      end
    endcase
    core_next.pv_raw = (core_next.st == ST_READ);
    core_next.eol_raw = (core_reg.st == ST_EOL);
    core_next.eof_raw = (core_reg.st == ST_EOL) && (core_reg.line_cnt >= core_reg.nlines);
    // Programmable delay of window and markers
    dpv = irs_dly_f(core_reg.dly[3:0]);
    dmk = irs_dly_f(core_reg.dly[7:4]);
    core_next.pv_h = {core_reg.pv_h[DLY_TAPS-2:0], core_next.pv_raw};
    core_next.eol_h = {core_reg.eol_h[DLY_TAPS-2:0], core_next.eol_raw};
    core_next.eof_h = {core_reg.eof_h[DLY_TAPS-2:0], core_next.eof_raw};
    core_next.pv_o = irs_tap_f(core_reg.pv_h, dpv, core_next.pv_raw);
    core_next.eol_o = irs_tap_f(core_reg.eol_h, dmk, core_next.eol_raw);
    core_next.eof_o = irs_tap_f(core_reg.eof_h, dmk, core_next.eof_raw);
    // Pixel output path
    one = core_reg.ctrl[CTRL_ONE_OUT];
    ain = (one && core_reg.pix_cnt[0]) ? pix_b_i : pix_a_i;
    core_next.pa = {core_reg.pa[2:0], ain};
    core_next.pb = {core_reg.pb[2:0], pix_b_i};
    core_next.pvp = {core_reg.pvp[2:0], core_reg.pv_raw};
    if (one) begin
      core_next.oa = core_reg.pa[LAT_ONE-2];
      core_next.ob = '0;
      core_next.ov = core_reg.pvp[LAT_ONE-2];
    end else begin
      core_next.oa = core_reg.pa[LAT_TWO-2];
      core_next.ob = core_reg.pb[LAT_TWO-2];
      core_next.ov = core_reg.pvp[LAT_TWO-2];
    end
    // Converters on half-rate clock, sample at its falling edge
    core_next.adc_clk = !core_reg.adc_clk;
    if (core_reg.adc_clk) begin
      core_next.c1 = {core_reg.c1[0], core_reg.oa};
      core_next.c2 = {core_reg.c2[0], core_reg.ob};
    end
    if (core_reg.ctrl[CTRL_ADC_ONE]) begin
      core_next.adc_d = core_reg.ctrl[CTRL_SWITCH] ? core_reg.c2[1] : core_reg.c1[1];
    end else begin
      core_next.adc_d = (core_reg.adc_clk ^ core_reg.ctrl[CTRL_SWITCH]) ?
                        core_reg.c2[1] : core_reg.c1[1];
    end
    // Serial upload writes
    if (par.wr) begin
      case (par.addr)
        U_CTRL: core_next.ctrl = par.data[2:0];
        U_NPIX: core_next.npix = par.data;
        U_NLINES: core_next.nlines = par.data;
        U_DELAY: core_next.dly = par.data[7:0];
        default: core_next.dly = core_reg.dly;
      endcase
    end
    // Wishbone classic slave
    core_next.ack = cyc_i && stb_i && !core_reg.ack;
    if (cyc_i && stb_i && !core_reg.ack) begin
      case (adr_i)
        A_CTRL: core_next.rdat = {29'h0, core_reg.ctrl};
        A_NPIX: core_next.rdat = {20'h0, core_reg.npix};
        A_NLINES: core_next.rdat = {20'h0, core_reg.nlines};
        A_DELAY: core_next.rdat = {24'h0, core_reg.dly};
        A_STATUS: core_next.rdat = {4'h0, core_reg.line_cnt, 13'h0, core_reg.st};
        default: core_next.rdat = 32'h0;
      endcase
    end
    if (cyc_i && stb_i && we_i && core_reg.ack) begin
      case (adr_i)
        A_CTRL: begin
          wv = irs_merge_f({29'h0, core_reg.ctrl}, dat_i, sel_i);
          core_next.ctrl = wv[2:0];
        end
        A_NPIX: begin
          wv = irs_merge_f({20'h0, core_reg.npix}, dat_i, sel_i);
          core_next.npix = wv[CW-1:0];
        end
        A_NLINES: begin
          wv = irs_merge_f({20'h0, core_reg.nlines}, dat_i, sel_i);
          core_next.nlines = wv[CW-1:0];
        end
        A_DELAY: begin
          wv = irs_merge_f({24'h0, core_reg.dly}, dat_i, sel_i);
          core_next.dly = wv[7:0];
        end
        default: wv = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_reg <= '0;
      core_reg.ctrl <= CTRL_RST;
      core_reg.npix <= NPIX_RST;
      core_reg.nlines <= NLINES_RST;
      core_reg.dly <= DELAY_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  assign dat_o = core_reg.rdat;
  assign ack_o = core_reg.ack;
  assign pix_valid_o = core_reg.pv_o;
  assign eol_o = core_reg.eol_o;
  assign eof_o = core_reg.eof_o;
  assign sample_sig_o = core_reg.smp_sig;
  assign sample_rst_o = core_reg.smp_rst;
  assign col_addr_o = core_reg.pix_cnt;
  assign analog_output_a_o = core_reg.oa;
  assign analog_output_b_o = core_reg.ob;
  assign out_valid_o = core_reg.ov;
  assign adc_clk_o = core_reg.adc_clk;
  assign adc_data_o = core_reg.adc_d;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_suspend;
    (core_reg.st == ST_SUSP && core_next.lc) |=> core_reg.st == ST_SUSP;
  endproperty
  a_suspend: assert property (p_suspend) else $error("left suspend early");

  property p_window_rise;
    $rose(core_reg.pv_raw) |-> $past(core_reg.st) == ST_BLANK && $past(core_reg.bc) == BLANK_LAST;
  endproperty
  a_window_rise: assert property (p_window_rise) else $error("window rose early");

  property p_window_fall;
    $fell(core_reg.pv_raw) |-> core_reg.pix_cnt >= core_reg.npix;
  endproperty
  a_window_fall: assert property (p_window_fall) else $error("window fell early");

  property p_eol;
    $fell(core_reg.pv_raw) |=> $rose(core_reg.eol_raw);
  endproperty
  a_eol: assert property (p_eol) else $error("end of line late");

  property p_eof;
    $rose(core_reg.eof_raw) |-> core_reg.line_cnt >= core_reg.nlines && !core_reg.pv_raw;
  endproperty
  a_eof: assert property (p_eof) else $error("end of frame wrong");

  property p_lat_two;
    ($rose(core_reg.pv_raw) && !core_reg.ctrl[CTRL_ONE_OUT]) |-> !core_reg.ov [*4] ##1 core_reg.ov;
  endproperty
  a_lat_two: assert property (p_lat_two) else $error("two-output latency");

  property p_lat_one;
    ($rose(core_reg.pv_raw) && core_reg.ctrl[CTRL_ONE_OUT]) |-> !core_reg.ov [*5] ##1 core_reg.ov;
  endproperty
  a_lat_one: assert property (p_lat_one) else $error("one-output latency");

  property p_delay;
    ($rose(core_reg.pv_raw) && core_reg.dly[3:0] == 4'h5) |-> ##3 $rose(core_reg.pv_o);
  endproperty
  a_delay: assert property (p_delay) else $error("window delay wrong");

  property p_sample_edge;
    $changed(core_reg.c1[0]) |-> $past(core_reg.adc_clk) && !core_reg.adc_clk;
  endproperty
  a_sample_edge: assert property (p_sample_edge) else $error("sample off falling edge");

  property p_pipe;
    core_reg.adc_clk |-> ##3 core_reg.c1[1] == $past(core_reg.oa, 3);
  endproperty
  a_pipe: assert property (p_pipe) else $error("converter pipeline depth");

  property p_line_clear;
    ($rose(core_reg.fs) && $past(core_reg.st) == ST_IDLE) |-> core_reg.line_cnt == '0;
  endproperty
  a_line_clear: assert property (p_line_clear) else $error("line count not cleared");

  property p_marker_short;
    $rose(core_reg.eol_raw) |-> ##2 !core_reg.eol_raw;
  endproperty
  a_marker_short: assert property (p_marker_short) else $error("marker too long");

  c_frame_end: cover property ($rose(core_reg.eof_raw));
  c_one_out: cover property (core_reg.ctrl[CTRL_ONE_OUT] && $rose(core_reg.ov));
  c_suspend: cover property (core_reg.st == ST_SUSP ##1 core_reg.st == ST_BLANK);
endmodule

// ===== bench/irs_ctl_model.sv
// Behavioural camera controller: frame and line pulses, optional marker feedback
`timescale 1ns/1ns
module irs_ctl_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fb_en_i,
  input wire logic eol_i,
  output logic frame_start_o,
  output logic line_adv_o
);
  logic line_man = 1'b0;
  logic [1:0] eol_dly = 2'h0;
  initial frame_start_o = 1'b0;
  // End-of-line fed back two cycles late, so line spacing stays equal
  always @(posedge clk_i) begin
    if (rst_i) begin
      eol_dly <= 2'h0;
    end else begin
      eol_dly <= {eol_dly[0], eol_i};
    end
  end
  assign line_adv_o = line_man | (fb_en_i & eol_dly[1]);
  task automatic pulse_frame();
    frame_start_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    frame_start_o <= 1'b0;
  endtask
  task automatic pulse_line(input int width);
    line_man <= 1'b1;
    repeat (width) @(posedge clk_i);
    line_man <= 1'b0;
  endtask
endmodule

// ===== bench/irs_core_tb_top.sv
// Self-checking bench of the image readout sequencer
`timescale 1ns/1ns
module irs_core_tb_top;
  import irs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic upload_clk_i = 1'b0;
  logic upload_data_i = 1'b0;
  logic reg_clock_i = 1'b0;
  logic [PW-1:0] pix_a_i = '0;
  logic [PW-1:0] pix_b_i = '0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'h0;
  logic we_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic fb_en = 1'b0;
  logic seeded = 1'b0;
  logic line_adv, frame_start, ack_o, pix_valid_o, eol_o, eof_o;
  logic sample_sig_o, sample_rst_o, out_valid_o, adc_clk_o;
  logic [31:0] dat_o, rd;
  logic [CW-1:0] col_addr_o;
  logic [PW-1:0] out_a, out_b, adc_data_o;
  logic pv_q = 1'b0, ov_q = 1'b0, eol_q = 1'b0, eof_q = 1'b0, adc_q = 1'b0;
  int err_total, checks, cyc_n, pv_rise, pv_fall, win_len, ov_rise, eol_rise, eol_len;
  int eof_rise, eof_cnt, win_cnt, ss_at, sr_at, adc_tog;
  int npix_m, nlines_m, lat_m, dlo_m, dhi_m, t0;
  int ov_idx, col_bl;
  logic [PW-1:0] pa_h[$], pb_h[$], oa_h[$], ob_h[$], ea, eb;
  logic live = 1'b0, sgl_m = 1'b0;
  logic [7:0] rst_adr [6] = '{A_CTRL, A_NPIX, A_NLINES, A_DELAY, A_STATUS, 8'h14};
  logic [31:0] rst_exp [6] = '{32'h0, 32'h280, 32'h1e0, 32'h0, 32'h0, 32'h0};

  always #50 clk_i = ~clk_i;

  irs_ctl_model u_ctl (.clk_i(clk_i), .rst_i(rst_i), .fb_en_i(fb_en), .eol_i(eol_o),
    .frame_start_o(frame_start), .line_adv_o(line_adv));

  irs_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .line_adv_i(line_adv),
    .frame_start_i(frame_start), .upload_clk_i(upload_clk_i), .upload_data_i(upload_data_i),
    .reg_clock_i(reg_clock_i), .pix_a_i(pix_a_i), .pix_b_i(pix_b_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
    .ack_o(ack_o), .pix_valid_o(pix_valid_o), .eol_o(eol_o), .eof_o(eof_o),
    .sample_sig_o(sample_sig_o), .sample_rst_o(sample_rst_o), .col_addr_o(col_addr_o),
    .analog_output_a_o(out_a), .analog_output_b_o(out_b), .out_valid_o(out_valid_o),
    .adc_clk_o(adc_clk_o), .adc_data_o(adc_data_o));

  // Random column words every cycle
  always @(posedge clk_i) begin
    if (seeded) begin
      pix_a_i <= PW'($urandom);
      pix_b_i <= PW'($urandom);
    end
  end

  // Output monitor, sampled mid-cycle
  always @(negedge clk_i) begin
    cyc_n++;
    if (pix_valid_o === 1'b1 && !pv_q) begin
      pv_rise = cyc_n;
      win_cnt++;
    end
    if (pix_valid_o !== 1'b1 && pv_q) begin
      pv_fall = cyc_n;
      win_len = cyc_n - pv_rise;
    end
    if (out_valid_o === 1'b1 && !ov_q) ov_rise = cyc_n;
    if (eol_o === 1'b1 && !eol_q) eol_len = 0;
    if (eol_o === 1'b1 && !eol_q) eol_rise = cyc_n;
    if (eol_o === 1'b1) eol_len++;
    if (eof_o === 1'b1 && !eof_q) begin
      eof_rise = cyc_n;
      eof_cnt++;
    end
    if (sample_sig_o === 1'b1) begin
      ss_at = cyc_n;
      col_bl = col_addr_o;
    end
    if (sample_rst_o === 1'b1) sr_at = cyc_n;
    if (adc_clk_o !== adc_q) adc_tog++;
    // Reference pipeline: last eight input and output words
    pa_h.push_back(pix_a_i);
    pb_h.push_back(pix_b_i);
    oa_h.push_back(out_a);
    ob_h.push_back(out_b);
    if (pa_h.size() > 8) begin
      pa_h.delete(0);
      pb_h.delete(0);
      oa_h.delete(0);
      ob_h.delete(0);
    end
    if (out_valid_o === 1'b1 && pa_h.size() == 8) begin
      if (!ov_q) ov_idx = 0;
      ea = (lat_m == LAT_ONE && ov_idx[0]) ? pb_h[7 - lat_m] : pa_h[7 - lat_m];
      eb = (lat_m == LAT_ONE) ? PW'(0) : pb_h[7 - lat_m];
      chk("output a", ea, out_a);
      chk("output b", eb, out_b);
      ov_idx++;
    end
    if (live && pa_h.size() == 8) begin
      ea = (adc_clk_o === 1'b1) ? oa_h[3] : (sgl_m ? oa_h[2] : ob_h[2]);
      chk("converter data", ea, adc_data_o);
    end
    pv_q = (pix_valid_o === 1'b1);
    ov_q = (out_valid_o === 1'b1);
    eol_q = (eol_o === 1'b1);
    eof_q = (eof_o === 1'b1);
    adc_q = adc_clk_o;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    err_total++;
    $display("[FAIL] %s expected done seen timeout", what);
    tally_and_finish();
  endtask

  // One classic Wishbone cycle; read data lands in rd
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    if (ack_o !== 1'b1) hang("wishbone ack");
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Serial upload, each clock level held three cycles, each data bit six
  task automatic upload(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      upload_data_i <= w[i];
      repeat (3) @(posedge clk_i);
      upload_clk_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      upload_clk_i <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
    reg_clock_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reg_clock_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  function automatic int dly_of(input int c);
    return (c >= 3) ? c - 2 : 0;
  endfunction

  // Whole frame: first pulses by hand, later lines from fed-back markers
  task automatic run_frame(input int hold);
    int w0, e0, n;
    w0 = win_cnt;
    e0 = eof_cnt;
    n = 0;
    live = 1'b1;
    u_ctl.pulse_frame();
    repeat (4) @(posedge clk_i);
    fb_en <= 1'b1;
    u_ctl.pulse_line(hold);
    chk("windows while suspended", w0, win_cnt);
    while (eof_cnt == e0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (eof_cnt == e0) hang("end of frame");
    repeat (8) @(posedge clk_i);
    fb_en <= 1'b0;
    chk("windows per frame", nlines_m, win_cnt - w0);
    chk("window length", npix_m, win_len);
    chk("data latency", lat_m - dlo_m, ov_rise - pv_rise);
    chk("eol after window", 1 + dhi_m - dlo_m, eol_rise - pv_fall);
    chk("eol width", 2, eol_len);
    chk("eof with last eol", eol_rise, eof_rise);
    chk("sample order", 1, sr_at - ss_at);
    chk("readout after sampling", 1, pv_rise > sr_at);
    chk("column count at blank", 0, col_bl);
    chk("column count at line end", npix_m, col_addr_o);
    live = 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    void'($urandom(32'h7090));
    seeded <= 1'b1;
    wb(1'b1, 8'h14, 32'hffffffff);
    wb(1'b1, A_STATUS, 32'hffffffff);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, rst_adr[i], 32'h0);
      chk("reset value", rst_exp[i], rd);
    end
    npix_m = 4 + $urandom_range(12);
    wb(1'b1, A_NPIX, 32'(npix_m));
    wb(1'b0, A_NPIX, 32'h0);
    chk("pixels per line", npix_m, rd);
    nlines_m = 3;
    upload({U_NLINES, 12'h003});
    wb(1'b0, A_NLINES, 32'h0);
    chk("uploaded lines", nlines_m, rd);
    lat_m = LAT_TWO;
    dlo_m = 0;
    dhi_m = 0;
    run_frame(2);
    wb(1'b1, A_CTRL, 32'h3);
    sgl_m = 1'b1;
    lat_m = LAT_ONE;
    run_frame(2);
    wb(1'b1, A_CTRL, 32'h0);
    sgl_m = 1'b0;
    wb(1'b1, A_DELAY, 32'h65);
    lat_m = LAT_TWO;
    dlo_m = dly_of(5);
    dhi_m = dly_of(6);
    run_frame(30);
    @(posedge clk_i);
    t0 = adc_tog;
    repeat (16) @(posedge clk_i);
    chk("converter clock toggles", 16, adc_tog - t0);
    tally_and_finish();
  end
endmodule
